// [verilog/sbl_defines.svh]
// constants for the serial boot loader front end
`ifndef SBL_DEFINES_SVH
`define SBL_DEFINES_SVH

// ----------------------------------------
// mode bytes and command codes
// ----------------------------------------
`define SBL_ASYNC_CODE 8'h86
`define SBL_SYNC_CODE 8'h30
`define SBL_CMD_RAM 8'h10
`define SBL_CMD_SUM 8'h20
`define SBL_CMD_INFO 8'h30
`define SBL_CMD_ERASE 8'h40

// ----------------------------------------
// acknowledge codes
// ----------------------------------------
`define SBL_NIB_RXERR 4'h8
`define SBL_NIB_BADCMD 4'h1
`define SBL_ACK_PWD_RXERR 8'h18
`define SBL_ACK_PWD_FAIL 8'h11
`define SBL_ACK_OK 8'h10

// ----------------------------------------
// password and information areas
// ----------------------------------------
`define SBL_PWD_LEN 4'hC
`define SBL_ERASED 8'hFF
`define SBL_SUM_OK 8'h00
`define SBL_INFO_BASE_A 32'h3F87FF00
`define SBL_INFO_BASE_B 32'h3F81FF00
`define SBL_PWD_BASE_A 32'h3F87FF04
`define SBL_PWD_BASE_B 32'h3F81FF04

// ----------------------------------------
// baud measurement
// ----------------------------------------
`define SBL_SYNC_DIV_SHIFT 4
`define SBL_ASYNC_LOW_BITS_SHIFT 1
`define SBL_ASYNC_BYTE_LOWS 27'h0000005
`define SBL_SYNC_LAST_EDGE 3'h7
`define SBL_DIV_MIN 16'h0002
`define SBL_DIV_MAX 16'hFFFF

`endif

// [verilog/sbl_pkg.sv]
// types for the serial boot loader front end
package sbl_pkg;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_ASYNC = 2'b01,
    M_SYNC = 2'b10,
    M_DONE = 2'b11
  } sbl_meter_st_t;

  typedef enum logic [3:0] {
    S_MEASURE = 4'b0000,
    S_ABORT = 4'b0001,
    S_RX_ON = 4'b0010,
    S_ECHO = 4'b0011,
    S_CMD_WAIT = 4'b0100,
    S_CMD_ACK = 4'b0101,
    S_PWD = 4'b0110,
    S_PWD_ACK = 4'b0111,
    S_HANDLER = 4'b1000
  } sbl_state_t;

endpackage : sbl_pkg

// [verilog/sbl_baud_meter.sv]
// first-byte mode and bit time measurement
`timescale 1ns/10ps
`include "sbl_defines.svh"

module sbl_baud_meter
  import sbl_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // serial pins
  input wire logic rxd_i,
  input wire logic host_serial_clock_i,
  // result
  output logic done_o,
  output logic sync_mode_o,
  output logic [26:0] bit_len_o
);

  sbl_meter_st_t st, next_st;
  logic [26:0] cnt, next_cnt;
  logic [26:0] next_bit_len;
  logic [2:0] edges, next_edges;
  logic rxd_q, sclk_q, next_sync;
  logic rxd_fall, rxd_rise, sclk_rise;

  assign rxd_fall = rxd_q & ~rxd_i;
  assign rxd_rise = ~rxd_q & rxd_i;
  assign sclk_rise = ~sclk_q & host_serial_clock_i;
  assign done_o = (st == M_DONE);

  // ----------------------------------------
  // measurement sequencer
  // ----------------------------------------
  // clock edges before any start bit mean the host runs the clock
  always_comb begin
    next_st = st;
    next_cnt = (cnt == '1) ? cnt : cnt + 27'h1;
    next_bit_len = bit_len_o;
    next_edges = edges;
    next_sync = sync_mode_o;
    unique case (st)
      M_IDLE: begin
        next_cnt = 27'h1;
        if (sclk_rise) begin
          next_st = M_SYNC;
          next_sync = 1'b1;
          next_edges = 3'h1;
        end else if (rxd_fall) begin
          next_st = M_ASYNC;
        end
      end
      M_ASYNC: begin
        // 0x86 opens with two low bit times
        if (rxd_rise && bit_len_o == 27'h0) begin
          next_bit_len = cnt;
        end
        if (bit_len_o != 27'h0 && cnt == 27'(bit_len_o * `SBL_ASYNC_BYTE_LOWS)) begin
          next_st = M_DONE;
        end
      end
      M_SYNC: begin
        if (sclk_rise) begin
          next_edges = edges + 3'h1;
          if (edges == 3'h1) begin
            next_bit_len = cnt;
          end
          if (edges == `SBL_SYNC_LAST_EDGE) begin
            next_st = M_DONE;
          end
        end
      end
      M_DONE: begin
        next_st = M_DONE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st <= M_IDLE;
      cnt <= 27'h0;
      bit_len_o <= 27'h0;
      edges <= 3'h0;
      sync_mode_o <= 1'b0;
      rxd_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      bit_len_o <= next_bit_len;
      edges <= next_edges;
      sync_mode_o <= next_sync;
      rxd_q <= rxd_i;
      sclk_q <= host_serial_clock_i;
    end
  end

endmodule : sbl_baud_meter

// [verilog/sbl_loader.sv]
// serial boot loader front end: mode, command and password phases
`timescale 1ns/10ps
`include "sbl_defines.svh"

module sbl_loader
  import sbl_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // raw pins seen during the first byte
  input wire logic rxd_i,
  input wire logic host_serial_clock_i,
  // part variant strap, high selects the smaller flash
  input wire logic part_variant_i,
  // byte receiver of the serial channel
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_err_i,
  // byte transmitter of the serial channel
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // serial channel setup
  output logic receiver_enable_bit_o,
  output logic serial_mode_reg_o,
  output logic [15:0] baud_divider_reg_o,
  output logic boot_abort_o,
  // stored password read port, data one cycle after address
  output logic [31:0] flash_addr_o,
  input wire logic [7:0] flash_rdata_i,
  // command handlers
  output logic [7:0] handler_cmd_o,
  output logic handler_go_o,
  output logic [31:0] info_base_o,
  output logic flash_erase_all_o,
  input wire logic handler_done_i,
  output logic security_indicator_o
);

  sbl_state_t st, next_st;
  logic meter_done, meter_sync;
  logic [26:0] bit_len;
  logic [26:0] div_wide;
  logic div_ok, rx_err_eff;
  logic [7:0] next_tx_data;
  logic next_tx_valid, next_rx_en, next_mode, next_abort;
  logic [15:0] next_div;
  logic [3:0] prev_hi, next_prev_hi;
  logic [3:0] pwd_idx, next_pwd_idx;
  logic [7:0] pwd_sum, next_pwd_sum;
  logic [7:0] first_stored, next_first_stored;
  logic pwd_rxerr, next_pwd_rxerr;
  logic pwd_miss, next_pwd_miss;
  logic all_same, next_all_same;
  logic [7:0] next_cmd;
  logic next_security;
  logic cmd_known;

  // ----------------------------------------
  // first byte measurement
  // ----------------------------------------
  sbl_baud_meter u_meter (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .rxd_i(rxd_i),
    .host_serial_clock_i(host_serial_clock_i),
    .done_o(meter_done),
    .sync_mode_o(meter_sync),
    .bit_len_o(bit_len)
  );

  // divider from the measured bit time
  always_comb begin
    if (meter_sync) begin
      div_wide = bit_len >> `SBL_SYNC_DIV_SHIFT;
    end else begin
      div_wide = bit_len >> `SBL_ASYNC_LOW_BITS_SHIFT;
    end
    div_ok = (div_wide[26:16] == 11'h0) && (div_wide[15:0] >= `SBL_DIV_MIN)
      && (div_wide[15:0] <= `SBL_DIV_MAX);
  end

  // error flags from the receiver mean nothing in clocked mode
  assign rx_err_eff = rx_err_i & ~serial_mode_reg_o;
  assign cmd_known = (rx_data_i == `SBL_CMD_RAM) || (rx_data_i == `SBL_CMD_SUM)
    || (rx_data_i == `SBL_CMD_INFO) || (rx_data_i == `SBL_CMD_ERASE);
  assign flash_addr_o = (part_variant_i ? `SBL_PWD_BASE_B : `SBL_PWD_BASE_A)
    + {28'h0, pwd_idx};
  assign info_base_o = part_variant_i ? `SBL_INFO_BASE_B : `SBL_INFO_BASE_A;
  assign handler_go_o = (st == S_HANDLER);
  assign flash_erase_all_o = (st == S_HANDLER) && (handler_cmd_o == `SBL_CMD_ERASE);

  // ----------------------------------------
  // main sequencer
  // ----------------------------------------
  // one ack byte in flight at most, so the tx flop is the only buffer
  always_comb begin
    next_st = st;
    next_tx_valid = tx_valid_o && !tx_ready_i;
    next_tx_data = tx_data_o;
    next_rx_en = receiver_enable_bit_o;
    next_mode = serial_mode_reg_o;
    next_div = baud_divider_reg_o;
    next_abort = boot_abort_o;
    next_prev_hi = prev_hi;
    next_pwd_idx = pwd_idx;
    next_pwd_sum = pwd_sum;
    next_first_stored = first_stored;
    next_pwd_rxerr = pwd_rxerr;
    next_pwd_miss = pwd_miss;
    next_all_same = all_same;
    next_cmd = handler_cmd_o;
    next_security = security_indicator_o;
    unique case (st)
      S_MEASURE: begin
        next_rx_en = 1'b0;
        if (meter_done) begin
          if (meter_sync) begin
            next_mode = 1'b1;
            next_div = div_wide[15:0];
            next_st = S_RX_ON;
          end else if (div_ok) begin
            next_div = div_wide[15:0];
            next_st = S_RX_ON;
          end else begin
            next_abort = 1'b1;
            next_st = S_ABORT;
          end
        end
      end
      S_ABORT: begin
        next_st = S_ABORT;
      end
      S_RX_ON: begin
        next_rx_en = 1'b1;
        next_st = S_ECHO;
      end
      S_ECHO: begin
        next_tx_valid = 1'b1;
        next_tx_data = serial_mode_reg_o ? `SBL_SYNC_CODE : `SBL_ASYNC_CODE;
        next_st = S_CMD_ACK;
      end
      S_CMD_ACK: begin
        if (!tx_valid_o || tx_ready_i) begin
          next_st = S_CMD_WAIT;
        end
      end
      S_CMD_WAIT: begin
        if (rx_valid_i) begin
          next_tx_valid = 1'b1;
          next_pwd_idx = 4'h0;
          next_pwd_sum = 8'h00;
          next_pwd_rxerr = 1'b0;
          next_pwd_miss = 1'b0;
          next_all_same = 1'b1;
          next_st = S_CMD_ACK;
          if (rx_err_eff) begin
            next_tx_data = {prev_hi, `SBL_NIB_RXERR};
          end else if (cmd_known) begin
            next_tx_data = rx_data_i;
            next_prev_hi = rx_data_i[7:4];
            next_cmd = rx_data_i;
            next_st = (rx_data_i == `SBL_CMD_RAM) ? S_PWD : S_HANDLER;
          end else begin
            next_tx_data = {prev_hi, `SBL_NIB_BADCMD};
          end
        end
      end
      S_PWD: begin
        // twelve password bytes then the checksum byte
        if (rx_valid_i) begin
          next_pwd_sum = pwd_sum + rx_data_i;
          next_pwd_rxerr = pwd_rxerr | rx_err_eff;
          if (pwd_idx == `SBL_PWD_LEN) begin
            next_st = S_PWD_ACK;
          end else begin
            next_pwd_idx = pwd_idx + 4'h1;
            next_pwd_miss = pwd_miss | (rx_data_i != flash_rdata_i);
            if (pwd_idx == 4'h0) begin
              next_first_stored = flash_rdata_i;
            end else if (flash_rdata_i != first_stored) begin
              next_all_same = 1'b0;
            end
          end
        end
      end
      S_PWD_ACK: begin
        if (!tx_valid_o) begin
          next_tx_valid = 1'b1;
          next_st = S_CMD_ACK;
          if (pwd_rxerr) begin
            next_tx_data = `SBL_ACK_PWD_RXERR;
          end else if (pwd_sum != `SBL_SUM_OK) begin
            next_tx_data = `SBL_ACK_PWD_FAIL;
          end else if (pwd_miss || (all_same && first_stored != `SBL_ERASED)) begin
            next_tx_data = `SBL_ACK_PWD_FAIL;
          end else begin
            next_tx_data = `SBL_ACK_OK;
            next_st = S_HANDLER;
          end
        end
      end
      S_HANDLER: begin
        if (handler_done_i) begin
          if (handler_cmd_o == `SBL_CMD_ERASE) begin
            next_security = 1'b1;
          end
          next_st = S_CMD_WAIT;
        end
      end
      default: begin
        next_st = S_MEASURE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st <= S_MEASURE;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      receiver_enable_bit_o <= 1'b0;
      serial_mode_reg_o <= 1'b0;
      baud_divider_reg_o <= 16'h0000;
      boot_abort_o <= 1'b0;
      prev_hi <= 4'h0;
      pwd_idx <= 4'h0;
      pwd_sum <= 8'h00;
      first_stored <= 8'h00;
      pwd_rxerr <= 1'b0;
      pwd_miss <= 1'b0;
      all_same <= 1'b1;
      handler_cmd_o <= 8'h00;
      security_indicator_o <= 1'b0;
    end else begin
      st <= next_st;
      tx_valid_o <= next_tx_valid;
      tx_data_o <= next_tx_data;
      receiver_enable_bit_o <= next_rx_en;
      serial_mode_reg_o <= next_mode;
      baud_divider_reg_o <= next_div;
      boot_abort_o <= next_abort;
      prev_hi <= next_prev_hi;
      pwd_idx <= next_pwd_idx;
      pwd_sum <= next_pwd_sum;
      first_stored <= next_first_stored;
      pwd_rxerr <= next_pwd_rxerr;
      pwd_miss <= next_pwd_miss;
      all_same <= next_all_same;
      handler_cmd_o <= next_cmd;
      security_indicator_o <= next_security;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_cmd_rx;
    st == S_CMD_WAIT && rx_valid_i;
  endsequence

  property p_rx_off_first;
    @(posedge mclk_i) disable iff (!rst_n_i)
      st == S_MEASURE |=> !receiver_enable_bit_o;
  endproperty
  a_rx_off_first: assert property (p_rx_off_first) else $error("receiver on in first byte");

  property p_rx_before_echo;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(tx_valid_o) && $past(st) == S_ECHO |-> receiver_enable_bit_o;
  endproperty
  a_rx_before_echo: assert property (p_rx_before_echo) else $error("echo before receiver on");

  property p_echo_code;
    @(posedge mclk_i) disable iff (!rst_n_i)
      st == S_ECHO |=> tx_valid_o && tx_data_o == (serial_mode_reg_o ? 8'h30 : 8'h86);
  endproperty
  a_echo_code: assert property (p_echo_code) else $error("wrong mode echo");

  property p_abort_sticks;
    @(posedge mclk_i) disable iff (!rst_n_i)
      boot_abort_o |=> boot_abort_o && !tx_valid_o && st == S_ABORT;
  endproperty
  a_abort_sticks: assert property (p_abort_sticks) else $error("abort left");

  property p_cmd_rxerr;
    @(posedge mclk_i) disable iff (!rst_n_i)
      s_cmd_rx ##0 (rx_err_i && !serial_mode_reg_o)
        |=> tx_data_o[3:0] == 4'h8 && tx_data_o[7:4] == $past(prev_hi) && st == S_CMD_ACK;
  endproperty
  a_cmd_rxerr: assert property (p_cmd_rxerr) else $error("bad rx error ack");

  property p_sync_no_err;
    @(posedge mclk_i) disable iff (!rst_n_i)
      serial_mode_reg_o && tx_valid_o |-> tx_data_o[3:0] != 4'h8;
  endproperty
  a_sync_no_err: assert property (p_sync_no_err) else $error("error ack in sync mode");

  property p_cmd_echo;
    @(posedge mclk_i) disable iff (!rst_n_i)
      s_cmd_rx ##0 (!rx_err_eff && cmd_known) |=> tx_valid_o && tx_data_o == $past(rx_data_i);
  endproperty
  a_cmd_echo: assert property (p_cmd_echo) else $error("command not echoed");

  property p_ram_to_pwd;
    @(posedge mclk_i) disable iff (!rst_n_i)
      s_cmd_rx ##0 (!rx_err_eff && rx_data_i == 8'h10) |=> st == S_PWD && pwd_idx == 4'h0;
  endproperty
  a_ram_to_pwd: assert property (p_ram_to_pwd) else $error("ram command not taken");

  property p_pwd_ok;
    @(posedge mclk_i) disable iff (!rst_n_i)
      st == S_PWD_ACK && !tx_valid_o && !pwd_rxerr && pwd_sum == 8'h00 && !pwd_miss
        && !(all_same && first_stored != 8'hFF) |=> tx_data_o == 8'h10 ##1 st == S_HANDLER;
  endproperty
  a_pwd_ok: assert property (p_pwd_ok) else $error("good password not acked");

  property p_pwd_sum;
    @(posedge mclk_i) disable iff (!rst_n_i)
      st == S_PWD_ACK && !tx_valid_o && !pwd_rxerr && pwd_sum != 8'h00
        |=> tx_data_o == 8'h11 && st == S_CMD_ACK;
  endproperty
  a_pwd_sum: assert property (p_pwd_sum) else $error("checksum fail not reported");

  property p_erase_sec;
    @(posedge mclk_i) disable iff (!rst_n_i)
      flash_erase_all_o && handler_done_i |=> security_indicator_o && st == S_CMD_WAIT;
  endproperty
  a_erase_sec: assert property (p_erase_sec) else $error("security bit not set");

endmodule : sbl_loader

// [test/sbl_host_model.sv]
// host controller model for the boot serial channel and the stored password area
`timescale 1ns/10ps

module sbl_host_model (
  // clock and part strap
  input wire logic mclk_i,
  input wire logic part_variant_i,
  // first byte pins
  output logic rxd_o,
  output logic host_serial_clock_o,
  // byte link
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_err_o,
  output logic tx_ready_o,
  // stored password read port
  input wire logic [31:0] flash_addr_i,
  output logic [7:0] flash_rdata_o
);

  logic [7:0] store [12];
  logic [27:0] area;

  initial begin
    rxd_o = 1'b1;
    host_serial_clock_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_err_o = 1'b0;
    tx_ready_o = 1'b1;
    flash_rdata_o = 8'h00;
  end

  // ----------------------------------------
  // stored area and transmitter
  // ----------------------------------------
  assign area = part_variant_i ? 28'h3F81FF0 : 28'h3F87FF0;

  // data one cycle after address; off the area it keeps toggling so stale reads show
  always @(posedge mclk_i) begin
    if (flash_addr_i[31:4] == area && flash_addr_i[3:0] >= 4'h4) begin
      flash_rdata_o <= store[flash_addr_i[3:0] - 4'h4];
    end else begin
      flash_rdata_o <= ~flash_rdata_o;
    end
  end

  // transmitter ready is drawn at random each cycle, so some acknowledges are stretched
  always @(negedge mclk_i) begin
    tx_ready_o <= 1'($urandom_range(0, 1));
  end

  // ----------------------------------------
  // host tasks
  // ----------------------------------------
  // character frame lsb first, bit_len cycles per bit
  task automatic send_async(input logic [7:0] b, input int bit_len);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk_i);
      rxd_o = frame[i];
      repeat (bit_len - 1) @(negedge mclk_i);
    end
  endtask : send_async

  // host clock at the slow rate; data pin idles as only clock edges time the byte
  task automatic send_sync(input logic [7:0] b, input int period);
    for (int i = 0; i < 8; i++) begin
      @(negedge mclk_i);
      host_serial_clock_o = 1'b0;
      repeat (period / 2) @(negedge mclk_i);
      host_serial_clock_o = 1'b1;
      repeat (period / 2 - 1) @(negedge mclk_i);
    end
    @(negedge mclk_i);
    host_serial_clock_o = 1'b0;
  endtask : send_sync

  // one received byte; data inverts after the strobe so nothing stale matches
  task automatic send_byte(input logic [7:0] b, input logic err);
    @(negedge mclk_i);
    rx_valid_o = 1'b1;
    rx_data_o = b;
    rx_err_o = err;
    @(negedge mclk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~b;
    rx_err_o = 1'b0;
    repeat (3) @(negedge mclk_i);
  endtask : send_byte

  // twelve bytes then the two's complement checksum, adj spoils it on purpose
  task automatic send_password(input logic [7:0] pw [12], input logic [7:0] adj,
                               input int err_at);
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < 12; i++) begin
      sum = sum + pw[i];
      send_byte(pw[i], i == err_at);
    end
    send_byte(8'h00 - sum + adj, err_at == 12);
  endtask : send_password

endmodule : sbl_host_model

// [test/sbl_loader_tb.sv]
// self-checking bench for the serial boot loader front end
`timescale 1ns/10ps

module sbl_loader_tb;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk_i, rst_n_i, part_variant_i, handler_done_i;
  logic rxd_i, host_serial_clock_i, rx_valid_i, rx_err_i, tx_ready_i;
  logic [7:0] rx_data_i, tx_data_o, flash_rdata_i, handler_cmd_o;
  logic tx_valid_o, receiver_enable_bit_o, serial_mode_reg_o, boot_abort_o;
  logic handler_go_o, flash_erase_all_o, security_indicator_o;
  logic [15:0] baud_divider_reg_o;
  logic [31:0] flash_addr_o, info_base_o;
  int err_count, checked, cycles;
  logic [7:0] exp_q [$];
  logic [7:0] pw [12];
  logic [7:0] codes [3] = '{8'h20, 8'h30, 8'h40};
  logic [7:0] acks [6] = '{8'h10, 8'h11, 8'h11, 8'h18, 8'h11, 8'h10};

  sbl_loader DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .rxd_i(rxd_i),
    .host_serial_clock_i(host_serial_clock_i), .part_variant_i(part_variant_i),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_err_i(rx_err_i),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
    .receiver_enable_bit_o(receiver_enable_bit_o), .serial_mode_reg_o(serial_mode_reg_o),
    .baud_divider_reg_o(baud_divider_reg_o), .boot_abort_o(boot_abort_o),
    .flash_addr_o(flash_addr_o), .flash_rdata_i(flash_rdata_i),
    .handler_cmd_o(handler_cmd_o), .handler_go_o(handler_go_o), .info_base_o(info_base_o),
    .flash_erase_all_o(flash_erase_all_o), .handler_done_i(handler_done_i),
    .security_indicator_o(security_indicator_o));

  sbl_host_model host (.mclk_i(mclk_i), .part_variant_i(part_variant_i), .rxd_o(rxd_i),
    .host_serial_clock_o(host_serial_clock_i), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .rx_err_o(rx_err_i), .tx_ready_o(tx_ready_i),
    .flash_addr_i(flash_addr_o), .flash_rdata_o(flash_rdata_i));

  // ----------------------------------------
  // clock, checking and closing
  // ----------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, e, s);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // every accepted byte takes the oldest note; the receiver must already be on
  always @(posedge mclk_i) begin
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("unexpected tx_data_o: expected none, seen %h", tx_data_o);
      end else begin
        check("tx_data_o", exp_q.pop_front(), tx_data_o);
      end
      check("receiver_enable_bit_o", 1'b1, receiver_enable_bit_o);
    end
  end

  // hang guard, far above the few thousand cycles the tests need
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      close_out();
    end
  end

  // ----------------------------------------
  // stimulus tasks
  // ----------------------------------------
  task automatic do_reset();
    rst_n_i = 1'b0;
    part_variant_i = 1'($urandom_range(0, 1));
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1'b1;
    check("tx_valid_o", 1'b0, tx_valid_o);
    check("boot_abort_o", 1'b0, boot_abort_o);
    check("security_indicator_o", 1'b0, security_indicator_o);
    @(negedge mclk_i);
  endtask : do_reset

  task automatic drain();
    while (exp_q.size() != 0) @(negedge mclk_i);
  endtask : drain

  task automatic cmd(input logic [7:0] c, input logic err, input logic [7:0] ack);
    exp_q.push_back(ack);
    host.send_byte(c, err);
    drain();
  endtask : cmd

  task automatic run_handler(input logic [7:0] c);
    while (handler_go_o !== 1'b1) @(negedge mclk_i);
    check("handler_cmd_o", c, handler_cmd_o);
    check("flash_erase_all_o", c == 8'h40, flash_erase_all_o);
    if (c == 8'h30) begin
      check("info_base_o", part_variant_i ? 32'h3F81FF00 : 32'h3F87FF00, info_base_o);
    end
    handler_done_i = 1'b1;
    @(negedge mclk_i);
    handler_done_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    check("handler_go_o", 1'b0, handler_go_o);
    if (c == 8'h40) check("security_indicator_o", 1'b1, security_indicator_o);
  endtask : run_handler

  // kinds: good, mismatch, bad sum, receive error, uniform store, erased store
  task automatic pwd_case(input int kind, input logic [7:0] ack);
    int j;
    j = $urandom_range(0, 11);
    for (int i = 0; i < 12; i++) begin
      host.store[i] = (kind == 4) ? 8'h5A : (kind == 5) ? 8'hFF : 8'($urandom);
      pw[i] = host.store[i];
    end
    if (kind == 1) pw[j] = pw[j] ^ 8'h01;
    cmd(8'h10, 1'b0, 8'h10);
    exp_q.push_back(ack);
    host.send_password(pw, (kind == 2) ? 8'h01 : 8'h00, (kind == 3) ? j : 99);
    drain();
    if (ack == 8'h10) run_handler(8'h10);
  endtask : pwd_case

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    part_variant_i = 1'b0;
    handler_done_i = 1'b0;
    void'($urandom(32'hF04B7CA5));
    do_reset();
    exp_q.push_back(8'h86);
    fork
      host.send_async(8'h86, 16);
      begin
        repeat (100) @(negedge mclk_i);
        check("receiver_enable_bit_o", 1'b0, receiver_enable_bit_o);
      end
    join
    // host echo wait, scaled down from seconds to a few dozen cycles
    for (int w = 0; w < 40 && tx_valid_o !== 1'b1; w++) @(negedge mclk_i);
    check("tx_valid_o", 1'b1, tx_valid_o);
    drain();
    check("baud_divider_reg_o", 16'h0010, baud_divider_reg_o);
    check("serial_mode_reg_o", 1'b0, serial_mode_reg_o);
    cmd(8'h55, 1'b0, 8'h01);
    foreach (codes[i]) begin
      cmd(codes[i], 1'b0, codes[i]);
      run_handler(codes[i]);
      if (i == 1) cmd(8'hA5, 1'b0, {codes[i][7:4], 4'h1});
      else cmd(8'h20, 1'b1, {codes[i][7:4], 4'h8});
    end
    $display("test async_commands done");
    for (int k = 0; k < 6; k++) pwd_case(k, acks[k]);
    $display("test async_password done");
    // clocked link: divider is one sixteenth of the 320 cycle slow period
    do_reset();
    exp_q.push_back(8'h30);
    host.send_sync(8'h30, 320);
    drain();
    check("baud_divider_reg_o", 16'h0014, baud_divider_reg_o);
    check("serial_mode_reg_o", 1'b1, serial_mode_reg_o);
    cmd(8'h30, 1'b1, 8'h30);
    run_handler(8'h30);
    pwd_case(3, 8'h10);
    $display("test sync_link done");
    // rate too fast for the divider
    do_reset();
    host.send_async(8'h86, 1);
    repeat (20) @(negedge mclk_i);
    check("boot_abort_o", 1'b1, boot_abort_o);
    host.send_byte(8'h10, 1'b0);
    repeat (50) @(negedge mclk_i);
    check("tx_valid_o", 1'b0, tx_valid_o);
    $display("test abort done");
    close_out();
  end

endmodule : sbl_loader_tb
